/* common/tpc_pkg.sv */
package tpc_pkg;
   // register word indices (printed offsets not all multiples of four: byte address is index * 4)
   localparam logic [11:0] IDX_ZONE_LO = 12'h000;
   localparam logic [11:0] IDX_ZONE_HI = 12'h001;
   localparam logic [11:0] IDX_WARN_LO = 12'h002;
   localparam logic [11:0] IDX_WARN_HI = 12'h003;
   localparam logic [11:0] IDX_TIMING = 12'hFA5;
   localparam logic [11:0] IDX_LP_THR = 12'hFA6;
   localparam logic [11:0] IDX_LP_DUR = 12'hFA7;
   localparam logic [11:0] IDX_HT_THR = 12'hFA8;
   localparam logic [11:0] IDX_MASK_LO = 12'hFAC;
   localparam logic [11:0] IDX_MASK_HI = 12'hFAD;
   // block's own registers (tuning, setup, status)
   localparam logic [11:0] IDX_GAIN = 12'h010;
   localparam logic [11:0] IDX_INTEG = 12'h011;
   localparam logic [11:0] IDX_DERIV = 12'h012;
   localparam logic [11:0] IDX_SETUP = 12'h013;
   localparam logic [11:0] IDX_STATUS = 12'h014;
   localparam logic [11:0] IDX_DEVIATION = 12'h015;
   localparam logic [11:0] IDX_SETPT_BASE = 12'h040;
   localparam logic [11:0] IDX_OUT_BASE = 12'h080;
   localparam logic [11:0] IDX_STATE_BASE = 12'h004;
   // reset values
   localparam logic [15:0] RST_TIMING = 16'h0102;
   localparam logic [15:0] RST_GAIN = 16'h006E;
   localparam logic [15:0] RST_INTEG = 16'h0011;
   localparam logic [15:0] RST_DERIV = 16'h0032;
   localparam logic [15:0] RST_LP_THR = 16'h005A;
   localparam logic [15:0] RST_LP_DUR = 16'h0258;
   localparam logic [15:0] RST_HT_THR = 16'h0DAC;
   localparam logic [15:0] RST_MASK = 16'hFFFF;
   localparam logic [15:0] RST_SETUP = 16'h2000;
   localparam logic [15:0] RST_DEVIATION = 16'h0014;
   // limits
   localparam logic [15:0] GAIN_MAX = 16'h270F;
   localparam logic [15:0] LP_THR_MIN = 16'h0050;
   localparam logic [15:0] LP_THR_MAX = 16'h0064;
   localparam logic [15:0] LP_DUR_MIN = 16'h003C;
   localparam logic [15:0] HT_THR_MIN = 16'h0064;
   localparam logic [3:0] HOT_SCANS = 4'hA;
   localparam logic [31:0] OUT_FULL = 32'h0000_2710;
   localparam int TS_BASE = 10;
   // time base: one tick every 0.1 s at 200 MHz
   localparam int CLK_PERIOD_PS = 5000;
   localparam longint TICK_PS = 64'd100_000_000_000;
   localparam int TICK_CYCLES = int'(TICK_PS / CLK_PERIOD_PS);
   localparam int TICKS_PER_SEC = 10;

   typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_NEXT} tpc_phase_t;

   typedef struct packed {
      logic [1:0] htrans;
      logic [11:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic hsel;
      logic hready;
      logic [31:0] hwdata;
   } tpc_ahb_req_t;

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } tpc_ahb_rsp_t;
endpackage : tpc_pkg

/* verilog/tpc_pid_temp_loop.sv */
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - output is P plus summed I minus D
// - error is set point minus measurement
// - gain 1..9999, constants 0..9999
// - interval only 10,20,40,80,160,320 tenths
// - zero integral constant adds nothing
// - zero derivative constant adds nothing
// - default interval four seconds
// - default tuning 110, 17, 50
// - heat when select 1, cool when 0
// - output drives time-proportional relay pulse
// - output words kept from output base
// - set points read from set-point base
// - bad start or count raises error, skips
// - in-zone bit from deviation, else alarm
// - ten hot scans set warning, alarm
// - long large power without zone warns
// - working words zero, one hold in-zone bits
// - words two, three warnings; rest internal
// - low byte selects solution interval
// - high byte selects output cycle
// - timing taken when next enabled
// - control starts after all channels read
// - per-point masks hold outputs off
// - large power threshold 80..100, default 90
// - large power duration 60..65535, default 600
// - warning threshold 100..65535, default 3500
module tpc_pid_temp_loop #(
   parameter int NPTS = 32,
   parameter int TICK_CNT = tpc_pkg::TICK_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [13:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic loop_enable,
   input wire logic heat_select,
   input wire logic channels_read,
   input wire logic [NPTS*16-1:0] measured_value,
   output logic [NPTS-1:0] solid_state_relay,
   output logic alarm_output,
   output logic error_output
);
   typedef struct packed {
      logic [15:0] timing, gain, integ, deriv, lp_thr, lp_dur, ht_thr;
      logic [15:0] mask_lo, mask_hi, setup, deviation;
      logic [2:0] ts_sel, cyc_sel;        // latched timing selects
      logic run;                          // enabled and started
      logic [31:0] tick_cnt;              // cycles to 0.1 s
      logic [15:0] ts_cnt, cyc_cnt;       // tenths counters
      logic [31:0] zone, warn;
      logic alarm, err;
      logic wr_pend;                      // write data phase pending
      logic [11:0] wr_idx;
      logic [31:0] rdata;
      logic [NPTS-1:0] relay;             // registered relay pulses
   } tpc_state_t;

   tpc_state_t s_r, s_nxt;
   logic signed [31:0] setp_r [NPTS];     // set points by point
   logic signed [31:0] out_r [NPTS];      // computed outputs
   logic signed [47:0] isum_r [NPTS];     // integral accumulators
   logic signed [31:0] prev_r [NPTS];     // last measurement
   logic [3:0] hot_r [NPTS];              // hot scan counts
   logic [15:0] lp_r [NPTS];              // large power seconds
   logic [31:0] cycle_pos;
   logic [15:0] pv_w [NPTS];              // measurement per point
   logic signed [31:0] out_w [NPTS];      // next computed outputs
   logic signed [47:0] isum_w [NPTS];     // next integral sums
   logic [NPTS-1:0] act_mask;             // points under control
   logic [31:0] mask_all;                 // both enable masks

   // tenths of a second for a select code, codes above 5 saturate
   function automatic logic [15:0] sel_tenths(input logic [7:0] code);
      logic [2:0] c;
      c = (code > 8'h05) ? 3'h5 : code[2:0];
      return 16'(tpc_pkg::TS_BASE) << c;
   endfunction : sel_tenths

   // clamp a value into lo..hi
   function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp16

   // channel of a point counted from the start point
   function automatic logic [4:0] chan_of(input logic [5:0] sp, input int j);
      return 5'(sp + 6'(j));
   endfunction : chan_of

   // relay on while the cycle position lags the output share
   function automatic logic on_now(input logic signed [31:0] val, input logic [31:0] pos,
                                   input logic [15:0] len);
      return 64'(pos) * 64'(tpc_pkg::OUT_FULL) < 64'(unsigned'(val)) * 64'(len);
   endfunction : on_now

   // output at or above the large-power share of full scale
   function automatic logic big_out(input logic signed [31:0] val, input logic [15:0] pct);
      return 64'(unsigned'(val)) * 64'd100 >= 64'(pct) * 64'(tpc_pkg::OUT_FULL);
   endfunction : big_out

   // one solution of one point: integral first, then clamped output
   function automatic void pid_step(input logic signed [31:0] e,
                                    input logic signed [31:0] dpv,
                                    input logic signed [47:0] isum, input logic [15:0] kc,
                                    input logic [15:0] ti, input logic [15:0] td,
                                    input logic [15:0] ts,
                                    output logic signed [47:0] isum_o,
                                    output logic signed [31:0] out_o);
      logic signed [63:0] kc_s, full, inc, d, acc;
      kc_s = 64'(signed'({1'b0, kc}));
      full = 64'(signed'({1'b0, tpc_pkg::OUT_FULL}));
      // integral grows by gain x constant x interval x error
      inc = kc_s * 64'(signed'({1'b0, ti})) * 64'(signed'({1'b0, ts})) * 64'(e)
            / 64'sd60000;
      // derivative: measurement slope over the interval
      d = kc_s * 64'(signed'({1'b0, td})) * 64'(dpv) * 64'sd6
          / 64'(signed'({1'b0, ts}));
      // clamped sum avoids windup past full scale
      acc = (ti == 16'h0) ? 64'sh0 : 64'(isum) + inc;
      acc = (acc < 64'sh0) ? 64'sh0 : ((acc > full) ? full : acc);
      isum_o = 48'(acc);
      if (td == 16'h0) begin
         d = 64'sh0;
      end
      acc = kc_s * 64'(e) + 64'(isum_o) - d;
      acc = (acc < 64'sh0) ? 64'sh0 : ((acc > full) ? full : acc);
      out_o = 32'(acc);
   endfunction : pid_step

   logic addr_ok, take_wr;
   logic [11:0] a_idx;
   logic [5:0] start_pt, npts_cfg;
   logic ts_tick, cyc_tick, sec_tick;
   logic cfg_bad;

   assign a_idx = haddr[13:2];
   assign addr_ok = hsel && hready && htrans[1];
   assign take_wr = addr_ok && hwrite;
   assign start_pt = s_r.setup[5:0];
   assign npts_cfg = s_r.setup[13:8];
   // start 0..31, count 1..32, sum at most 32
   assign cfg_bad = (start_pt > 6'd31) || (npts_cfg == 6'd0) || (npts_cfg > 6'd32)
                    || ({1'b0, start_pt} + {1'b0, npts_cfg} > 7'd32);
   assign sec_tick = s_r.run && (s_r.tick_cnt == 32'(TICK_CNT - 1))
                     && (s_r.ts_cnt % 16'(tpc_pkg::TICKS_PER_SEC) == 16'h0);
   assign ts_tick = s_r.run && (s_r.tick_cnt == 32'(TICK_CNT - 1))
                    && (s_r.ts_cnt == sel_tenths({5'h0, s_r.ts_sel}) - 16'h1);
   assign cyc_tick = s_r.run && (s_r.tick_cnt == 32'(TICK_CNT - 1))
                     && (s_r.cyc_cnt == sel_tenths({5'h0, s_r.cyc_sel}) - 16'h1);
   assign cycle_pos = {16'h0, s_r.cyc_cnt};

   // register file and control state
   always_comb begin
      s_nxt = s_r;
      s_nxt.wr_pend = take_wr;
      if (addr_ok) begin
         s_nxt.wr_idx = a_idx;
      end
      // write data phase
      if (s_r.wr_pend) begin
         unique case (s_r.wr_idx)
            tpc_pkg::IDX_TIMING: s_nxt.timing = hwdata[15:0];
            tpc_pkg::IDX_GAIN: s_nxt.gain = clamp16(hwdata[15:0], 16'h1,
                                                   tpc_pkg::GAIN_MAX);
            tpc_pkg::IDX_INTEG: s_nxt.integ = clamp16(hwdata[15:0], 16'h0,
                                                     tpc_pkg::GAIN_MAX);
            tpc_pkg::IDX_DERIV: s_nxt.deriv = clamp16(hwdata[15:0], 16'h0,
                                                     tpc_pkg::GAIN_MAX);
            tpc_pkg::IDX_LP_THR: s_nxt.lp_thr = clamp16(hwdata[15:0], tpc_pkg::LP_THR_MIN,
                                                       tpc_pkg::LP_THR_MAX);
            tpc_pkg::IDX_LP_DUR: s_nxt.lp_dur = clamp16(hwdata[15:0], tpc_pkg::LP_DUR_MIN,
                                                       16'hFFFF);
            tpc_pkg::IDX_HT_THR: s_nxt.ht_thr = clamp16(hwdata[15:0], tpc_pkg::HT_THR_MIN,
                                                       16'hFFFF);
            tpc_pkg::IDX_MASK_LO: s_nxt.mask_lo = hwdata[15:0];
            tpc_pkg::IDX_MASK_HI: s_nxt.mask_hi = hwdata[15:0];
            tpc_pkg::IDX_SETUP: s_nxt.setup = hwdata[15:0];
            tpc_pkg::IDX_DEVIATION: s_nxt.deviation = hwdata[15:0];
            default: ;
         endcase
      end
      // read data for the following data phase
      s_nxt.rdata = 32'h0;
      if (addr_ok && !hwrite) begin
         unique case (a_idx)
            tpc_pkg::IDX_ZONE_LO: s_nxt.rdata = {16'h0, s_r.zone[15:0]};
            tpc_pkg::IDX_ZONE_HI: s_nxt.rdata = {16'h0, s_r.zone[31:16]};
            tpc_pkg::IDX_WARN_LO: s_nxt.rdata = {16'h0, s_r.warn[15:0]};
            tpc_pkg::IDX_WARN_HI: s_nxt.rdata = {16'h0, s_r.warn[31:16]};
            tpc_pkg::IDX_TIMING: s_nxt.rdata = {16'h0, s_r.timing};
            tpc_pkg::IDX_GAIN: s_nxt.rdata = {16'h0, s_r.gain};
            tpc_pkg::IDX_INTEG: s_nxt.rdata = {16'h0, s_r.integ};
            tpc_pkg::IDX_DERIV: s_nxt.rdata = {16'h0, s_r.deriv};
            tpc_pkg::IDX_LP_THR: s_nxt.rdata = {16'h0, s_r.lp_thr};
            tpc_pkg::IDX_LP_DUR: s_nxt.rdata = {16'h0, s_r.lp_dur};
            tpc_pkg::IDX_HT_THR: s_nxt.rdata = {16'h0, s_r.ht_thr};
            tpc_pkg::IDX_MASK_LO: s_nxt.rdata = {16'h0, s_r.mask_lo};
            tpc_pkg::IDX_MASK_HI: s_nxt.rdata = {16'h0, s_r.mask_hi};
            tpc_pkg::IDX_SETUP: s_nxt.rdata = {16'h0, s_r.setup};
            tpc_pkg::IDX_DEVIATION: s_nxt.rdata = {16'h0, s_r.deviation};
            tpc_pkg::IDX_STATUS: s_nxt.rdata = {29'h0, s_r.run, s_r.err, s_r.alarm};
            // internal state word: solution interval progress
            tpc_pkg::IDX_STATE_BASE: s_nxt.rdata = {16'h0, s_r.ts_cnt};
            default: begin
               if (a_idx >= tpc_pkg::IDX_SETPT_BASE
                   && a_idx < tpc_pkg::IDX_SETPT_BASE + 12'(NPTS)) begin
                  s_nxt.rdata = setp_r[5'(a_idx - tpc_pkg::IDX_SETPT_BASE)];
               end else if (a_idx >= tpc_pkg::IDX_OUT_BASE
                            && a_idx < tpc_pkg::IDX_OUT_BASE + 12'(NPTS)) begin
                  s_nxt.rdata = out_r[5'(a_idx - tpc_pkg::IDX_OUT_BASE)];
               end
            end
         endcase
      end
      // enable, start and time base
      s_nxt.err = loop_enable && cfg_bad;
      if (!loop_enable || cfg_bad) begin
         s_nxt.run = 1'b0;
         s_nxt.ts_sel = (s_r.timing[7:0] > 8'h05) ? 3'h5 : s_r.timing[2:0];
         s_nxt.cyc_sel = (s_r.timing[15:8] > 8'h05) ? 3'h5 : s_r.timing[10:8];
         s_nxt.tick_cnt = 32'h0;
         s_nxt.ts_cnt = 16'h0;
         s_nxt.cyc_cnt = 16'h0;
      end else if (!s_r.run) begin
         s_nxt.run = channels_read;
      end else begin
         if (s_r.tick_cnt == 32'(TICK_CNT - 1)) begin
            s_nxt.tick_cnt = 32'h0;
            s_nxt.ts_cnt = ts_tick ? 16'h0 : s_r.ts_cnt + 16'h1;
            s_nxt.cyc_cnt = cyc_tick ? 16'h0 : s_r.cyc_cnt + 16'h1;
         end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 32'h1;
         end
      end
      // zone, warning and alarm on each solution
      if (ts_tick) begin
         for (int i = 0; i < NPTS; i++) begin
            logic signed [31:0] e;
            e = setp_r[i] - 32'(signed'({1'b0, pv_w[i]}));
            s_nxt.zone[i] = (e <= $signed({16'h0, s_r.deviation}))
                            && (-e <= $signed({16'h0, s_r.deviation}));
            if (hot_r[i] == tpc_pkg::HOT_SCANS - 4'h1
                && pv_w[i] >= s_r.ht_thr) begin
               s_nxt.warn[i] = 1'b1;
            end
            if (lp_r[i] >= s_r.lp_dur && !s_nxt.zone[i]) begin
               s_nxt.warn[i] = 1'b1;
            end
         end
         s_nxt.alarm = (|(~s_nxt.zone & act_mask)) || (|s_nxt.warn);
      end
      if (!loop_enable) begin
         s_nxt.alarm = 1'b0;
      end
      // time-proportional relay pulses, off at once on disable
      s_nxt.relay = '0;
      for (int j = 0; j < NPTS; j++) begin
         if (loop_enable && !cfg_bad && s_r.run && act_mask[j]
             && on_now(out_r[j], cycle_pos, sel_tenths({5'h0, s_r.cyc_sel}))) begin
            s_nxt.relay[chan_of(start_pt, j)] = 1'b1;
         end
      end
   end

   // bus answers with no wait state, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_r.rdata;
   assign solid_state_relay = s_r.relay;
   assign alarm_output = s_r.alarm;
   assign error_output = s_r.err;
   assign mask_all = {s_r.mask_hi, s_r.mask_lo};

   // per-point measurement, error and next solution
   always_comb begin
      for (int j = 0; j < NPTS; j++) begin
         logic signed [31:0] pv_s;
         logic signed [31:0] e_s;
         logic signed [31:0] dpv_s;
         pv_s = 32'(signed'({1'b0, measured_value[int'(chan_of(start_pt, j)) * 16 +: 16]}));
         // cooling runs the loop with the error reversed
         e_s = heat_select ? setp_r[j] - pv_s : pv_s - setp_r[j];
         dpv_s = heat_select ? pv_s - prev_r[j] : prev_r[j] - pv_s;
         pv_w[j] = 16'(pv_s);
         act_mask[j] = (6'(j) < npts_cfg) && mask_all[j];
         pid_step(e_s, dpv_s, isum_r[j], s_r.gain, s_r.integ, s_r.deriv,
                  sel_tenths({5'h0, s_r.ts_sel}), isum_w[j], out_w[j]);
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
         s_r.timing <= tpc_pkg::RST_TIMING;
         s_r.ts_sel <= tpc_pkg::RST_TIMING[2:0];
         s_r.cyc_sel <= tpc_pkg::RST_TIMING[10:8];
         s_r.gain <= tpc_pkg::RST_GAIN;
         s_r.integ <= tpc_pkg::RST_INTEG;
         s_r.deriv <= tpc_pkg::RST_DERIV;
         s_r.lp_thr <= tpc_pkg::RST_LP_THR;
         s_r.lp_dur <= tpc_pkg::RST_LP_DUR;
         s_r.ht_thr <= tpc_pkg::RST_HT_THR;
         s_r.mask_lo <= tpc_pkg::RST_MASK;
         s_r.mask_hi <= tpc_pkg::RST_MASK;
         s_r.setup <= tpc_pkg::RST_SETUP;
         s_r.deviation <= tpc_pkg::RST_DEVIATION;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   // per-point memories: set points, solutions, integrals, counters
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int j = 0; j < NPTS; j++) begin
            setp_r[j] <= 32'sh0;
            out_r[j] <= 32'sh0;
            isum_r[j] <= 48'sh0;
            prev_r[j] <= 32'sh0;
            hot_r[j] <= 4'h0;
            lp_r[j] <= 16'h0;
         end
      end else if (clk_en) begin
         for (int j = 0; j < NPTS; j++) begin
            // set point writes land in the data phase
            if (s_r.wr_pend && s_r.wr_idx == tpc_pkg::IDX_SETPT_BASE + 12'(j)) begin
               setp_r[j] <= hwdata;
            end
            if (!s_r.run) begin
               // track the input while idle so the first slope is flat
               prev_r[j] <= 32'(signed'({1'b0, pv_w[j]}));
               out_r[j] <= 32'sh0;
               hot_r[j] <= 4'h0;
               lp_r[j] <= 16'h0;
            end else if (ts_tick) begin
               out_r[j] <= out_w[j];
               isum_r[j] <= isum_w[j];
               prev_r[j] <= 32'(signed'({1'b0, pv_w[j]}));
               // consecutive hot solutions, saturating
               if (pv_w[j] < s_r.ht_thr) begin
                  hot_r[j] <= 4'h0;
               end else if (hot_r[j] != tpc_pkg::HOT_SCANS) begin
                  hot_r[j] <= hot_r[j] + 4'h1;
               end
            end
            // seconds of large output without reaching the zone
            if (s_r.run && sec_tick) begin
               if (big_out(out_r[j], s_r.lp_thr) && !s_r.zone[j]) begin
                  lp_r[j] <= (lp_r[j] == 16'hFFFF) ? lp_r[j] : lp_r[j] + 16'h1;
               end else begin
                  lp_r[j] <= 16'h0;
               end
            end
            // integrals stay cleared while disabled
            if (!loop_enable) begin
               isum_r[j] <= 48'sh0;
            end
         end
      end
   end
endmodule : tpc_pid_temp_loop
`default_nettype wire

/* tb/tpc_temp_model.sv */
`timescale 1ns/10ps
`default_nettype none
// multiplexed temperature module: fills one channel per cycle during the first sweep only
module tpc_temp_model #(
   parameter int NPTS = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   output logic [NPTS*16-1:0] measured_value,
   output logic channels_read
);
   logic [7:0] cnt_r; // channel being refreshed
   // values stay below the default hot threshold of 3500; ready once all read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 8'h00;
         channels_read <= 1'b0;
         measured_value <= '0;
      end else begin
         cnt_r <= cnt_r + 8'h01;
         // values settle after the first sweep so the slope term stays quiet
         if (!channels_read) begin
            measured_value[int'(cnt_r[4:0])*16 +: 16] <= 16'($urandom_range(1023, 0));
         end
         if (cnt_r == 8'(NPTS - 1)) channels_read <= 1'b1;
      end
   end
endmodule : tpc_temp_model
`default_nettype wire

/* tb/tpc_loop_chk.sv */
`timescale 1ns/10ps
`default_nettype none
// port-level checks of the loop block
module tpc_loop_chk #(
   parameter int NPTS = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic loop_enable,
   input wire logic channels_read,
   input wire logic [NPTS-1:0] solid_state_relay,
   input wire logic alarm_output,
   input wire logic error_output
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic seen_r; // channels seen read since reset
   // sticky flag of the first completed sweep
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) seen_r <= 1'b0;
      else if (channels_read) seen_r <= 1'b1;
   end
   chk_off_disabled: assert property (!loop_enable [*2] |-> solid_state_relay == '0)
      else $error("relay on while disabled");
   chk_fall_off: assert property ($fell(loop_enable) |-> ##[0:2] solid_state_relay == '0)
      else $error("relay not off after disable");
   chk_rise_cause: assert property ($rose(solid_state_relay[0]) |-> $past(loop_enable))
      else $error("relay rose while disabled");
   chk_wait_read: assert property (!seen_r && !channels_read |-> solid_state_relay == '0)
      else $error("control before channels read");
   chk_error_skip: assert property (error_output |-> solid_state_relay == '0)
      else $error("relay on with bad setup");
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   chk_idle_ready: assert property (!hsel [*2] |-> hreadyout)
      else $error("slave stalls while idle");
   chk_wait_bound: assert property (!hreadyout |-> ##[1:8] hreadyout)
      else $error("bus wait too long");
   cover property ($rose(solid_state_relay[0]));
   cover property ($rose(alarm_output));
   cover property (!loop_enable ##1 loop_enable);
endmodule : tpc_loop_chk
bind tpc_pid_temp_loop tpc_loop_chk #(.NPTS(NPTS)) i_tpc_loop_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .hreadyout(hreadyout), .hresp(hresp), .loop_enable(loop_enable),
   .channels_read(channels_read), .solid_state_relay(solid_state_relay),
   .alarm_output(alarm_output), .error_output(error_output));
`default_nettype wire

/* tb/test_tpc_pid_temp_loop.sv */
`timescale 1ns/10ps
`default_nettype none
module test_tpc_pid_temp_loop;
   localparam int NP = 32;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic loop_enable = 1'b0, heat_select = 1'b1, hreadyout, hresp, alarm_output, error_output;
   logic channels_read;
   logic [13:0] haddr = '0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = '0, hrdata, rd, t;
   logic [NP*16-1:0] measured_value;
   logic [NP-1:0] solid_state_relay;
   int n_errors = 0, samples_checked = 0;
   // register reset table
   logic [11:0] idx_t [10] = '{tpc_pkg::IDX_TIMING, tpc_pkg::IDX_GAIN, tpc_pkg::IDX_INTEG,
      tpc_pkg::IDX_DERIV, tpc_pkg::IDX_LP_THR, tpc_pkg::IDX_LP_DUR, tpc_pkg::IDX_HT_THR,
      tpc_pkg::IDX_MASK_LO, tpc_pkg::IDX_MASK_HI, tpc_pkg::IDX_SETUP};
   logic [15:0] rst_t [10] = '{16'h0102, 16'h006E, 16'h0011, 16'h0032, 16'h005A, 16'h0258,
      16'h0DAC, 16'hFFFF, 16'hFFFF, tpc_pkg::RST_SETUP};
   always #2.5 hclk = ~hclk;
   tpc_pid_temp_loop #(.NPTS(NP), .TICK_CNT(4)) i_tpc_pid_temp_loop (.hclk(hclk),
      .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .loop_enable(loop_enable),
      .heat_select(heat_select), .channels_read(channels_read),
      .measured_value(measured_value), .solid_state_relay(solid_state_relay),
      .alarm_output(alarm_output), .error_output(error_output));
   tpc_temp_model #(.NPTS(NP)) i_tpc_temp_model (.hclk(hclk), .hresetn(hresetn),
      .measured_value(measured_value), .channels_read(channels_read));
   // timing word from interval and cycle selects
   function automatic logic [31:0] tmg(input logic [7:0] lo, input logic [7:0] hi);
      return {16'h0000, hi, lo};
   endfunction : tmg
   // counts and verdict
   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // hready is settled at the falling edge before the sampling edge
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (n >= 100) begin
         n_errors++;
         summarize();
      end
      rd = hrdata;
      @(posedge hclk);
   endtask : wait_rdy
   // one single word transfer, address phase then data phase
   task automatic bus(input logic [11:0] idx, input logic wr, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {idx, 2'b00};
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
   endtask : bus
   initial begin
      void'($urandom(86));
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 10; i++) begin
         bus(idx_t[i], 1'b0, 32'h0);
         chk(rd, {16'h0000, rst_t[i]});
      end
      bus(12'h7FF, 1'b0, 32'h0); // unmapped place
      chk(rd, 32'h0);
      t = tmg(8'($urandom_range(5, 0)), 8'($urandom_range(5, 0)));
      bus(tpc_pkg::IDX_TIMING, 1'b1, t);
      bus(tpc_pkg::IDX_TIMING, 1'b0, 32'h0);
      chk(rd, t);
      bus(tpc_pkg::IDX_TIMING, 1'b1, tmg(8'h00, 8'h00));
      bus(tpc_pkg::IDX_SETPT_BASE, 1'b1, 32'h0000_0FFF);
      bus(tpc_pkg::IDX_MASK_LO, 1'b1, 32'h0);
      bus(tpc_pkg::IDX_MASK_HI, 1'b1, 32'h0);
      loop_enable <= 1'b1;
      repeat (800) @(posedge hclk);
      chk(solid_state_relay, 32'h0);
      bus(tpc_pkg::IDX_MASK_LO, 1'b1, 32'h0000_FFFF);
      repeat (800) @(posedge hclk);
      chk({31'h0, solid_state_relay[0]}, 32'h1);
      chk({31'h0, alarm_output}, 32'h1);
      bus(tpc_pkg::IDX_ZONE_LO, 1'b0, 32'h0);
      chk({31'h0, rd[0]}, 32'h0);
      heat_select <= 1'b0;
      repeat (800) @(posedge hclk);
      chk({31'h0, solid_state_relay[0]}, 32'h0);
      loop_enable <= 1'b0;
      repeat (4) @(posedge hclk);
      chk(solid_state_relay, 32'h0);
      bus(tpc_pkg::IDX_SETUP, 1'b1, 32'h0);
      loop_enable <= 1'b1;
      repeat (4) @(posedge hclk);
      chk({31'h0, error_output}, 32'h1);
      chk(solid_state_relay, 32'h0);
      loop_enable <= 1'b0;
      @(posedge hclk);
      summarize();
   end
endmodule : test_tpc_pid_temp_loop
`default_nettype wire
